// ### include/ifd_pkg.sv
// constants and types shared by the instruction field decoder files
package ifd_pkg;
	localparam int unsigned INSN_W = 16;
	localparam int unsigned FILE_W = 8;
	localparam int unsigned PERIPH_W = 5;
	localparam int unsigned BITN_W = 3;
	localparam int unsigned K8_W = 8;
	localparam int unsigned K11_W = 11;
	localparam int unsigned TBL_W = 16;
	localparam int unsigned CSTAT_W = 8;
	localparam int unsigned OSC_PER_TCY = 4;

	// operand field positions inside the instruction word
	localparam int unsigned FLD_FILE_LSB = 0;
	localparam int unsigned FLD_PERIPH_LSB = 8;
	localparam int unsigned FLD_BITN_LSB = 8;
	localparam int unsigned FLD_K8_LSB = 0;
	localparam int unsigned FLD_K11_LSB = 0;
	localparam int unsigned FLD_D_POS = 8;
	localparam int unsigned FLD_S_POS = 8;
	localparam int unsigned FLD_I_POS = 8;
	localparam int unsigned FLD_T_POS = 9;
	localparam int unsigned FLD_TWR_POS = 10;

	// opcode match masks and values
	localparam logic [15:0] OP_SGRP_M = 16'hF800;
	localparam logic [15:0] OP_SGRP_V = 16'h2800;
	localparam logic [15:0] OP_TLONG_M = 16'hF800;
	localparam logic [15:0] OP_TLONG_V = 16'hA800;
	localparam logic [15:0] OP_TSHORT_V = 16'hA000;
	localparam logic [15:0] OP_PERI_M = 16'hC000;
	localparam logic [15:0] OP_PERI_V = 16'h4000;
	localparam logic [15:0] OP_NIB_M = 16'hF000;
	localparam logic [15:0] OP_BSET_V = 16'h8000;
	localparam logic [15:0] OP_BTST_V = 16'h9000;
	localparam logic [15:0] OP_LIT_V = 16'hB000;
	localparam logic [15:0] OP_BTG_M = 16'hF800;
	localparam logic [15:0] OP_BTG_V = 16'h3800;
	localparam logic [15:0] OP_CMP_M = 16'hFC00;
	localparam logic [15:0] OP_CMP_V = 16'h3000;
	localparam logic [15:0] OP_D_M = 16'hFE00;
	localparam logic [15:0] OP_DECSZ_V = 16'h1600;
	localparam logic [15:0] OP_INCSZ_V = 16'h1E00;
	localparam logic [15:0] OP_DECSNZ_V = 16'h2600;
	localparam logic [15:0] OP_INCSNZ_V = 16'h2400;
	localparam logic [15:0] OP_CTL_M = 16'hFE00;
	localparam logic [15:0] OP_CTL_V = 16'h0000;
	localparam logic [15:0] OP_MOVWF_M = 16'hFF00;
	localparam logic [15:0] OP_MOVWF_V = 16'h0100;
	localparam logic [15:0] OP_JMP_M = 16'hE000;
	localparam logic [15:0] OP_GOTO_V = 16'hC000;
	localparam logic [15:0] OP_CALL_V = 16'hE000;
	localparam logic [15:0] OP_LCALL_V = 16'hB700;
	localparam logic [15:0] OP_RETLIT_V = 16'hB600;
	localparam logic [15:0] OP_FULL_M = 16'hFFFF;
	localparam logic [15:0] OP_RET_V = 16'h0002;
	localparam logic [15:0] OP_RETI_V = 16'h0005;

	// register byte offsets
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_FIELDS = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_TPTR = 8'h10;
	localparam logic [7:0] OFF_TLAT = 8'h14;
	localparam logic [7:0] OFF_CSTAT = 8'h18;

	// control register layout and reset
	localparam int unsigned CTRL_PM_LSB = 0;
	localparam int unsigned CTRL_VAR_POS = 3;
	localparam int unsigned CTRL_COND_POS = 4;
	localparam int unsigned CTRL_EXT_POS = 5;
	localparam int unsigned CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h7;
	localparam logic [2:0] PM_PROT3 = 3'h0;
	localparam logic [1:0] PM_PROT2 = 2'h0;
	localparam logic [2:0] PM_BLANK3 = 3'h7;
	localparam logic [1:0] PM_BLANK2 = 2'h3;

	// status register of the core
	localparam int unsigned IRQ_DIS_POS = 4;
	localparam logic [7:0] CSTAT_RST = 8'h3C;
	localparam logic [7:0] CSTAT_MASK = 8'h3C;
	localparam logic [15:0] TBL_RST = 16'h0000;

	typedef enum logic [1:0] {IFD_Q1, IFD_Q2, IFD_Q3, IFD_Q4} ifd_phase_t;
endpackage

// ### include/ifd_fields_if.sv
// decoded instruction fields passed from the field decoder to the core
`timescale 1ns/100ps
`default_nettype none
interface ifd_fields_if;
	logic [15:0] word;
	logic [7:0]  file_addr;
	logic [4:0]  periph_addr;
	logic [2:0]  bit_num;
	logic [7:0]  k8;
	logic [10:0] k11;
	logic        to_accum;
	logic        to_file;
	logic        is_table;
	logic        tbl_write;
	logic        tbl_long;
	logic        tbl_hi;
	logic        tbl_inc;
	logic        is_skip;
	logic        is_pc_chg;
	logic        uses_k11;
	logic        d_bit;
	logic        s_bit;
	modport dec (input word, output file_addr, periph_addr, bit_num, k8, k11, to_accum,
		to_file, is_table, tbl_write, tbl_long, tbl_hi, tbl_inc, is_skip, is_pc_chg,
		uses_k11, d_bit, s_bit);
	modport core (output word, input file_addr, periph_addr, bit_num, k8, k11, to_accum,
		to_file, is_table, tbl_write, tbl_long, tbl_hi, tbl_inc, is_skip, is_pc_chg,
		uses_k11, d_bit, s_bit);
endinterface
`default_nettype wire

// ### rtl/ifd_field_decoder.sv
// combinational split of one instruction word into operand fields
`timescale 1ns/100ps
`default_nettype none
module ifd_field_decoder (
	ifd_fields_if.dec f    // word in, fields out
);
	import ifd_pkg::*;

	function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] v);
		return (w & m) == v;
	endfunction

	wire logic s_grp;
	wire logic peri;
	wire logic bset;
	wire logic btst;
	wire logic btg;
	wire logic lit;
	wire logic cmp;
	wire logic sk_d;
	wire logic ctl;
	wire logic movwf;
	wire logic byte_d;
	wire logic tlong;
	wire logic tshort;

	assign f.file_addr = f.word[FLD_FILE_LSB +: FILE_W];
	assign f.periph_addr = f.word[FLD_PERIPH_LSB +: PERIPH_W];
	assign f.bit_num = f.word[FLD_BITN_LSB +: BITN_W];
	assign f.k8 = f.word[FLD_K8_LSB +: K8_W];
	assign f.k11 = f.word[FLD_K11_LSB +: K11_W];
	assign f.d_bit = f.word[FLD_D_POS];
	assign f.s_bit = f.word[FLD_S_POS];

	assign s_grp = hit(f.word, OP_SGRP_M, OP_SGRP_V);
	assign peri = hit(f.word, OP_PERI_M, OP_PERI_V);
	assign bset = hit(f.word, OP_NIB_M, OP_BSET_V);
	assign btst = hit(f.word, OP_NIB_M, OP_BTST_V);
	assign btg = hit(f.word, OP_BTG_M, OP_BTG_V);
	assign lit = hit(f.word, OP_NIB_M, OP_LIT_V);
	assign cmp = hit(f.word, OP_CMP_M, OP_CMP_V);
	assign ctl = hit(f.word, OP_CTL_M, OP_CTL_V);
	assign movwf = hit(f.word, OP_MOVWF_M, OP_MOVWF_V);
	assign tlong = hit(f.word, OP_TLONG_M, OP_TLONG_V);
	assign tshort = hit(f.word, OP_TLONG_M, OP_TSHORT_V);
	assign sk_d = hit(f.word, OP_D_M, OP_DECSZ_V) | hit(f.word, OP_D_M, OP_INCSZ_V)
		| hit(f.word, OP_D_M, OP_DECSNZ_V) | hit(f.word, OP_D_M, OP_INCSNZ_V);
	// don't-care bits never reach a match
	assign byte_d = (f.word[15:14] == 2'h0) & ~s_grp & ~ctl & ~movwf
		& (f.word[13:12] != 2'h3);

	// d clear to accumulator, set to file
	// s clear to both, set to file only
	assign f.to_accum = (byte_d & ~f.d_bit) | (s_grp & ~f.s_bit) | (lit & ~f.is_pc_chg);
	assign f.to_file = (byte_d & f.d_bit) | s_grp | movwf | peri | bset | btg
		| (f.is_table & ~f.tbl_write);

	assign f.is_table = tlong | tshort;
	assign f.tbl_long = tlong;
	assign f.tbl_write = f.word[FLD_TWR_POS];
	assign f.tbl_hi = f.word[FLD_T_POS];
	assign f.tbl_inc = f.word[FLD_I_POS];

	assign f.is_skip = cmp | btst | sk_d;
	assign f.is_pc_chg = hit(f.word, OP_JMP_M, OP_GOTO_V) | hit(f.word, OP_JMP_M, OP_CALL_V)
		| hit(f.word, OP_MOVWF_M, OP_LCALL_V) | hit(f.word, OP_MOVWF_M, OP_RETLIT_V)
		| hit(f.word, OP_FULL_M, OP_RET_V) | hit(f.word, OP_FULL_M, OP_RETI_V);
	assign f.uses_k11 = hit(f.word, OP_JMP_M, OP_GOTO_V) | hit(f.word, OP_JMP_M, OP_CALL_V);
endmodule
`default_nettype wire

// ### rtl/ifd_core_timing.sv
// instruction field decode, cycle timing and code-protection gating with apb registers
//
// Behaviour
// - one sixteen-bit word split into opcode, operands
// - d zero to accumulator, one to file
// - s zero writes both, one file only
// - table pointer increments after instruction when set
// - t selects low or high latch byte
// - file address eight bits, 00h to FFh
// - peripheral address five bits, 00h to 1Fh
// - bit number plus file address
// - literal eight or eleven bits
// - one cycle unless skip, jump or long table
// - long table ops take two cycles, second nop
// - instruction cycle is four oscillator clocks
// - interrupt disable flag at status bit four
// - sixteen-bit pointer and byte-addressable sixteen-bit latch
// - unused bits zero, don't-care bits ignored
// - mode bits all zero select protected mode
// - protection blocks program memory access from outside
// - unprogrammed protection allows verify read-out
// - four phases: decode, read, execute, write
`timescale 1ns/100ps
`default_nettype none
module ifd_core_timing (
	input  wire logic        pclk,         // oscillator clock
	input  wire logic        presetn,      // async reset, low active
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction
	input  wire logic [7:0]  paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error, unmapped
	input  wire logic [7:0]  file_data,    // addressed file register value
	input  wire logic [15:0] pm_rdata,     // program memory read word
	output logic      [1:0]  phase,        // current phase q1..q4
	output logic             tcy_clk,      // oscillator divided by four
	output logic             forced_nop,   // second cycle running as nop
	output logic             wr_accum,     // q4 write to accumulator
	output logic             wr_file,      // q4 write to file register
	output logic      [7:0]  tbl_byte,     // latch byte bound for file
	output logic             pm_rd_en,     // program memory read strobe
	output logic             pm_wr_en,     // program memory write strobe
	output logic      [15:0] pm_addr,      // program memory address
	output logic      [15:0] pm_wdata,     // program memory write word
	output logic             irq_disabled  // global interrupt disable
);
	import ifd_pkg::*;

	ifd_fields_if fld ();

	ifd_field_decoder u_dec (
		.f (fld)
	);

	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
		return hi ? w[15:8] : w[7:0];
	endfunction

	function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
		input logic [7:0] b);
		return hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction

	ifd_phase_t       phase_q;
	ifd_phase_t       phase_d;
	logic             tcy_q;
	logic [15:0]      instr_q;
	logic             cur_q;
	logic             second_q;
	logic             pend_q;
	logic             pend_d;
	logic [15:0]      pend_word_q;
	logic [5:0]       ctrl_q;
	logic [15:0]      tptr_q;
	logic [15:0]      tptr_d;
	logic [15:0]      latch_q;
	logic [15:0]      latch_d;
	logic [7:0]       cstat_q;
	logic             wr_acc_q;
	logic             wr_file_q;
	logic [7:0]       tbyte_q;
	logic             rd_en_q;
	logic             wr_en_q;
	logic             pready_q;
	logic             pslverr_q;
	logic [31:0]      prdata_q;

	wire logic        acc;
	wire logic        wr;
	wire logic        sel_instr;
	wire logic        sel_ctrl;
	wire logic        sel_fields;
	wire logic        sel_status;
	wire logic        sel_tptr;
	wire logic        sel_tlat;
	wire logic        sel_cstat;
	wire logic        mapped;
	wire logic        stall;
	wire logic        ready_d;
	wire logic [31:0] rd_mux;
	wire logic [31:0] fields_w;
	wire logic [31:0] status_w;
	wire logic        prot;
	wire logic        pm_ok;
	wire logic        blank;
	wire logic        cond_true;
	wire logic        two_cyc;
	wire logic        drop_fetch;
	wire logic        end_tcy;
	wire logic        run;
	wire logic        tbl2;

	// apb decode
	assign acc = psel & penable & pready_q;
	assign wr = acc & pwrite;
	assign sel_instr = paddr == OFF_INSTR;
	assign sel_ctrl = paddr == OFF_CTRL;
	assign sel_fields = paddr == OFF_FIELDS;
	assign sel_status = paddr == OFF_STATUS;
	assign sel_tptr = paddr == OFF_TPTR;
	assign sel_tlat = paddr == OFF_TLAT;
	assign sel_cstat = paddr == OFF_CSTAT;
	assign mapped = sel_instr | sel_ctrl | sel_fields | sel_status | sel_tptr
		| sel_tlat | sel_cstat;
	// instruction write waits while a word is still pending
	assign stall = pwrite & sel_instr & pend_q;
	assign ready_d = psel & ~pready_q & ~stall;

	// eight-bit file address in the field view
	assign fields_w = {1'b0, fld.tbl_inc, fld.tbl_hi, fld.s_bit, fld.d_bit, fld.k11,
		fld.bit_num, fld.periph_addr, fld.file_addr};
	assign status_w = {22'h0, blank, prot, pm_ok, two_cyc, second_q, pend_q, cur_q,
		tcy_q, phase_q};
	assign rd_mux = sel_instr ? {16'h0000, instr_q}
		: sel_ctrl ? {26'h0, ctrl_q}
		: sel_fields ? fields_w
		: sel_status ? status_w
		: sel_tptr ? {16'h0000, tptr_q}
		: sel_tlat ? {16'h0000, latch_q}
		: sel_cstat ? {24'h000000, cstat_q}
		: 32'h00000000;

	// all mode bits zero means protected
	assign prot = ctrl_q[CTRL_VAR_POS]
		? (ctrl_q[CTRL_PM_LSB +: 2] == PM_PROT2)
		: (ctrl_q[CTRL_PM_LSB +: 3] == PM_PROT3);
	// external execution under protection loses program memory access
	assign pm_ok = ~prot | ~ctrl_q[CTRL_EXT_POS];
	assign blank = ctrl_q[CTRL_VAR_POS]
		? (ctrl_q[CTRL_PM_LSB +: 2] == PM_BLANK2)
		: (ctrl_q[CTRL_PM_LSB +: 3] == PM_BLANK3);

	assign cond_true = ctrl_q[CTRL_COND_POS];
	assign run = cur_q & ~second_q;
	assign end_tcy = phase_q == IFD_Q4;
	assign tbl2 = cur_q & second_q & fld.is_table & fld.tbl_long;
	// second cycle only for skip, jump or long table
	// long table ops always take two
	assign two_cyc = fld.tbl_long | fld.is_pc_chg | (fld.is_skip & cond_true);
	// prefetched word thrown away on skip or jump
	assign drop_fetch = run & end_tcy & two_cyc & ~fld.tbl_long;
	assign fld.word = instr_q;

	always_comb begin
		case (phase_q)
			IFD_Q1: phase_d = IFD_Q2;
			IFD_Q2: phase_d = IFD_Q3;
			IFD_Q3: phase_d = IFD_Q4;
			IFD_Q4: phase_d = IFD_Q1;
			default: phase_d = IFD_Q1;
		endcase
	end

	// a new write wins over the drop of the old word
	always_comb begin
		pend_d = pend_q;
		if (drop_fetch | (end_tcy & ~(run & two_cyc))) begin
			pend_d = 1'b0;
		end
		if (wr & sel_instr) begin
			pend_d = 1'b1;
		end
	end

	// table pointer and latch next values; software writes win
	always_comb begin
		tptr_d = tptr_q;
		latch_d = latch_q;
		// first cycle loads the selected byte
		if (run & fld.is_table & fld.tbl_write & (phase_q == IFD_Q3)) begin
			latch_d = put_byte(latch_q, fld.tbl_hi, file_data);
		end
		if (tbl2 & end_tcy) begin
			if (~fld.tbl_write & pm_ok) begin
				latch_d = pm_rdata;
			end
			if (fld.tbl_inc) begin
				tptr_d = tptr_q + 16'h0001;
			end
		end
		if (run & ~fld.tbl_long & fld.is_table & fld.tbl_inc & end_tcy) begin
			tptr_d = tptr_q + 16'h0001;
		end
		if (wr & sel_tptr) begin
			tptr_d = pwdata[15:0];
		end
		if (wr & sel_tlat) begin
			latch_d = pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= IFD_Q1;
			tcy_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			tcy_q <= (phase_d == IFD_Q3) | (phase_d == IFD_Q4);
		end
	end

	// instruction sequencing at the end of each cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_q <= 16'h0000;
			cur_q <= 1'b0;
			second_q <= 1'b0;
			pend_q <= 1'b0;
			pend_word_q <= 16'h0000;
		end else begin
			pend_q <= pend_d;
			if (wr & sel_instr) begin
				pend_word_q <= pwdata[15:0];
			end
			if (end_tcy) begin
				if (run & two_cyc) begin
					second_q <= 1'b1;
				end else if (pend_q) begin
					instr_q <= pend_word_q;
					cur_q <= 1'b1;
					second_q <= 1'b0;
				end else begin
					cur_q <= 1'b0;
					second_q <= 1'b0;
				end
			end
		end
	end

	// q4 destination strobes and table byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_acc_q <= 1'b0;
			wr_file_q <= 1'b0;
			tbyte_q <= 8'h00;
		end else begin
			wr_acc_q <= run & (phase_q == IFD_Q3) & fld.to_accum;
			wr_file_q <= run & (phase_q == IFD_Q3) & fld.to_file;
			if (run & fld.is_table & ~fld.tbl_write & (phase_q == IFD_Q2)) begin
				tbyte_q <= pick_byte(latch_q, fld.tbl_hi);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tptr_q <= TBL_RST;
			latch_q <= TBL_RST;
		end else begin
			tptr_q <= tptr_d;
			latch_q <= latch_d;
		end
	end

	// memory strobes in q3 of the nop cycle only when allowed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_en_q <= 1'b0;
			wr_en_q <= 1'b0;
		end else begin
			rd_en_q <= tbl2 & (phase_q == IFD_Q2) & ~fld.tbl_write & pm_ok;
			wr_en_q <= tbl2 & (phase_q == IFD_Q2) & fld.tbl_write & pm_ok;
		end
	end

	// control and core status registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			cstat_q <= CSTAT_RST;
		end else begin
			if (wr & sel_ctrl) begin
				ctrl_q <= pwdata[CTRL_W-1:0];
			end
			if (wr & sel_cstat) begin
				cstat_q <= pwdata[CSTAT_W-1:0] & CSTAT_MASK;
			end
		end
	end

	// apb answer one cycle after setup unless stalled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= ready_d;
			if (ready_d) begin
				pslverr_q <= ~mapped;
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign phase = phase_q;
	assign tcy_clk = tcy_q;
	assign forced_nop = second_q;
	assign wr_accum = wr_acc_q;
	assign wr_file = wr_file_q;
	assign tbl_byte = tbyte_q;
	assign pm_rd_en = rd_en_q;
	assign pm_wr_en = wr_en_q;
	assign pm_addr = tptr_q;
	assign pm_wdata = latch_q;
	assign irq_disabled = cstat_q[IRQ_DIS_POS];
endmodule
`default_nettype wire

// ### testbench/ifd_core_timing_chk.sv
// port checker for the instruction timing block
`timescale 1ns/100ps
`default_nettype none
module ifd_core_timing_chk (
	input wire logic        pclk,         // clock
	input wire logic        presetn,      // reset
	input wire logic        psel,         // select
	input wire logic        penable,      // access
	input wire logic        pwrite,       // direction
	input wire logic [7:0]  paddr,        // address
	input wire logic [31:0] pwdata,       // write data
	input wire logic        pready,       // ready
	input wire logic [1:0]  phase,        // phase
	input wire logic        tcy_clk,      // cycle clock
	input wire logic        forced_nop,   // nop cycle
	input wire logic        wr_accum,     // accum write
	input wire logic        wr_file,      // file write
	input wire logic        pm_rd_en,     // mem read
	input wire logic        pm_wr_en,     // mem write
	input wire logic        irq_disabled  // irq disable
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_nop_cycle;
		forced_nop [*4] ##1 !forced_nop;
	endsequence
	sequence s_status_write;
		psel && penable && pready && pwrite && paddr == 8'h18;
	endsequence
	a_tcy_phase: assert property (tcy_clk == phase[1])
		else $error("cycle clock off phase");
	a_phase_step: assert property (phase != 2'h3 |=> phase == $past(phase) + 2'h1)
		else $error("phase did not advance");
	a_write_late: assert property ((wr_accum || wr_file) |-> phase == 2'h3 && !forced_nop)
		else $error("result write out of slot");
	a_nop_whole: assert property ($rose(forced_nop) |-> phase == 2'h0 ##0 s_nop_cycle)
		else $error("nop cycle length wrong");
	a_nop_quiet: assert property (forced_nop |-> !wr_accum && !wr_file)
		else $error("write in nop cycle");
	a_read_slot: assert property (pm_rd_en |-> forced_nop && phase == 2'h2 ##1 !pm_rd_en)
		else $error("memory read out of slot");
	a_write_slot: assert property (pm_wr_en |-> forced_nop && phase == 2'h2 ##1 !pm_wr_en)
		else $error("memory write out of slot");
	a_irq_flag: assert property (s_status_write |=> ##1 irq_disabled == $past(pwdata[4], 2))
		else $error("irq disable not status bit");
endmodule
bind ifd_core_timing ifd_core_timing_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .phase, .tcy_clk, .forced_nop, .wr_accum, .wr_file,
	.pm_rd_en, .pm_wr_en, .irq_disabled);
`default_nettype wire

// ### testbench/ifd_pm_model.sv
// program memory model answering table reads and writes
`timescale 1ns/100ps
`default_nettype none
module ifd_pm_model (
	input  wire logic        pclk,     // clock
	input  wire logic        pm_rd_en, // read strobe
	input  wire logic        pm_wr_en, // write strobe
	input  wire logic [15:0] pm_addr,  // word address
	input  wire logic [15:0] pm_wdata, // word to store
	output logic      [15:0] pm_rdata  // word read
);
	logic [15:0] mem [256];
	initial begin
		for (int a = 0; a < 256; a++) begin
			mem[a] = {8'(a) ^ 8'h5A, 8'(a)};
		end
		pm_rdata = 16'hA5A5;
	end
	always @(posedge pclk) begin
		if (pm_wr_en) begin
			mem[pm_addr[7:0]] <= pm_wdata;
		end
		pm_rdata <= pm_rd_en ? mem[pm_addr[7:0]] : ~pm_rdata;
	end
endmodule
`default_nettype wire

// ### testbench/ifd_core_timing_test.sv
// self-checking bench for the instruction timing block
`timescale 1ns/100ps
`default_nettype none
module ifd_core_timing_test;
	import ifd_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, file_data = 8'h00, tbl_byte;
	logic [31:0] pwdata = 32'h0, prdata, rdv, fld;
	logic [15:0] pm_rdata, pm_addr, pm_wdata;
	logic [1:0]  phase;
	logic        pready, pslverr, tcy_clk, forced_nop, wr_accum, wr_file, pm_rd_en, pm_wr_en;
	logic        irq_disabled, rerr;
	int          fails = 0, comparisons = 0, seed = 83372;
	int          n_acc = 0, n_fil = 0, n_nop = 0, n_rd = 0, n_wr = 0;
	logic [15:0] tv [6] = '{16'h0E00, 16'h2800, 16'h4000, 16'h8000, 16'hB000, 16'hC000};
	logic [15:0] tm [6] = '{16'hFE00, 16'hFE00, 16'hE000, 16'hF800, 16'hFF00, 16'hE000};
	logic [31:0] fm [6] = '{32'h080000FF, 32'h100000FF, 32'h00001FFF, 32'h0000E0FF,
		32'h00FF0000, 32'h07FF0000};
	logic [5:0]  pc [5] = '{6'h20, 6'h24, 6'h2C, 6'h2D, 6'h00};
	logic [4:0]  pp = 5'b10101, pa = 5'b11010;
	ifd_core_timing i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .file_data, .pm_rdata, .phase, .tcy_clk, .forced_nop, .wr_accum,
		.wr_file, .tbl_byte, .pm_rd_en, .pm_wr_en, .pm_addr, .pm_wdata, .irq_disabled);
	ifd_pm_model i_pm (.pclk, .pm_rd_en, .pm_wr_en, .pm_addr, .pm_wdata, .pm_rdata);
	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		n_acc += int'(wr_accum === 1'b1);
		n_fil += int'(wr_file === 1'b1);
		n_nop += int'(forced_nop === 1'b1);
		n_rd += int'(pm_rd_en === 1'b1);
		n_wr += int'(pm_wr_en === 1'b1);
	end
	function automatic logic [15:0] pm_word(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, a[7:0]};
	endfunction
	function automatic logic [31:0] fexp(input logic [15:0] w);
		return {1'b0, w[8], w[9], w[8], w[8], w[10:0], w[10:8], w[12:8], w[7:0]};
	endfunction
	task automatic give_verdict;
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 60);
		if (pready !== 1'b1) begin
			fails++;
			give_verdict();
		end
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic exec(input logic [15:0] w);
		int n;
		apb(1'b1, OFF_INSTR, {16'h0000, w});
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (rdv[4] !== 1'b0 && n < 40);
		if (rdv[4] !== 1'b0) begin
			fails++;
			give_verdict();
		end
		apb(1'b0, OFF_FIELDS, 32'h0);
		fld = rdv;
		repeat (12) @(posedge pclk);
	endtask
	initial begin
		logic [15:0] w, ptr, lat, ex;
		logic [7:0]  fd;
		int          a0, f0, q0, r0, w0, v;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(irq_disabled), 32'h1, "irq_disabled");
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rdv, 32'h7, "ctrl reset");
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdv[9:8]), 32'h2, "verify and protect");
		apb(1'b0, 8'h1C, 32'h0);
		chk({rdv[30:0], rerr}, 32'h1, "unmapped read");
		v = $random(seed);
		apb(1'b1, OFF_CSTAT, 32'(v));
		apb(1'b0, OFF_CSTAT, 32'h0);
		chk(rdv, 32'(v) & 32'h3C, "cpu status");
		chk(32'(irq_disabled), 32'(v[4]), "irq_disabled");
		for (int i = 0; i < 24; i++) begin
			w = (16'($random(seed)) & ~tm[i % 6]) | tv[i % 6];
			a0 = n_acc;
			f0 = n_fil;
			q0 = n_nop;
			exec(w);
			chk(fld & fm[i % 6], fexp(w) & fm[i % 6], "fields");
			if (i % 6 < 2) begin
				chk(32'(n_acc - a0), 32'(!w[8]), "accumulator write");
				chk(32'(n_fil - f0), 32'(i % 6 == 1 || w[8]), "file write");
			end
			chk(32'(n_nop - q0), (i % 6 == 5) ? 32'h4 : 32'h0, "nop cycles");
		end
		// word queued behind a jump is thrown away
		apb(1'b1, OFF_INSTR, 32'h0000C123);
		apb(1'b1, OFF_INSTR, 32'h00000E55);
		repeat (12) @(posedge pclk);
		apb(1'b0, OFF_INSTR, 32'h0);
		chk(rdv, 32'h0000C123, "dropped word");
		for (int c = 0; c < 2; c++) begin
			apb(1'b1, OFF_CTRL, 32'h7 | 32'(c << 4));
			q0 = n_nop;
			exec(16'h1600 | (16'($random(seed)) & 16'h01FF));
			chk(32'(n_nop - q0), 32'(c * 4), "skip cycles");
		end
		apb(1'b1, OFF_CTRL, 32'h7);
		for (int m = 0; m < 8; m++) begin
			ptr = 16'($random(seed)) & 16'h00FF;
			lat = 16'($random(seed));
			fd = 8'($random(seed));
			file_data <= fd;
			apb(1'b1, OFF_TPTR, 32'(ptr));
			apb(1'b1, OFF_TLAT, 32'(lat));
			r0 = n_rd;
			w0 = n_wr;
			q0 = n_nop;
			exec({5'h15, 3'(m), 8'h10});
			ex = !m[2] ? pm_word(ptr) : m[1] ? {fd, lat[7:0]} : {lat[15:8], fd};
			if (!m[2]) begin
				chk(32'(tbl_byte), 32'(m[1] ? lat[15:8] : lat[7:0]), "table byte");
			end
			chk(32'(n_rd - r0 + 2 * (n_wr - w0)), m[2] ? 32'h2 : 32'h1, "strobes");
			chk(32'(n_nop - q0), 32'h4, "table nop");
			apb(1'b0, OFF_TLAT, 32'h0);
			chk(rdv, 32'(ex), "table latch");
			chk(32'(pm_wdata), 32'(ex), "pm_wdata");
			apb(1'b0, OFF_TPTR, 32'h0);
			chk(rdv, 32'(ptr + 16'(m % 2)), "table pointer");
			chk(32'(pm_addr), 32'(ptr + 16'(m % 2)), "pm_addr");
		end
		for (int p = 0; p < 5; p++) begin
			apb(1'b1, OFF_CTRL, 32'(pc[p]));
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(32'(rdv[8:7]), 32'({pp[p], pa[p]}), "protect status");
			r0 = n_rd;
			exec(16'hA800);
			chk(32'(n_rd - r0), 32'(pa[p]), "guarded read");
		end
		give_verdict();
	end
endmodule
`default_nettype wire
